// ---- verilog/cie_regs.vh ----
/*
  Constants for the instruction execution block: operation codes,
  branch condition codes, status bit positions and cycle counts.
  Assumes it is included by bare name from files under verilog/ and testbench/.
*/
`ifndef CIE_REGS_VH
`define CIE_REGS_VH

// Operation codes presented on the op port
`define CIE_OP_NOP 6'h00
`define CIE_OP_BIT_CLR 6'h01
`define CIE_OP_BIT_SET 6'h02
`define CIE_OP_BIT_TOG 6'h03
`define CIE_OP_BIT_TEST 6'h04
`define CIE_OP_TEST_SKIP_CLR 6'h05
`define CIE_OP_TEST_SKIP_SET 6'h06
`define CIE_OP_TEST_THEN_SET 6'h07
`define CIE_OP_JUMP_COND 6'h08
`define CIE_OP_JUMP_ALWAYS 6'h09
`define CIE_OP_JUMP_REG 6'h0A
`define CIE_OP_CALL_LIT 6'h0B
`define CIE_OP_CALL_REG 6'h0C
`define CIE_OP_GOTO_LIT 6'h0D
`define CIE_OP_GOTO_REG 6'h0E
`define CIE_OP_COMPARE 6'h0F
`define CIE_OP_COMPARE_BORROW 6'h10
`define CIE_OP_CMP_SKIP 6'h11
`define CIE_OP_CMP_JUMP 6'h12
`define CIE_OP_IRQ_HOLD 6'h13
`define CIE_OP_INT_DIV 6'h14
`define CIE_OP_FRAC_QUOTIENT 6'h15
`define CIE_OP_LOOP 6'h16
`define CIE_OP_DECIMAL_ADJUST 6'h17
`define CIE_OP_FIRST_ONE_FROM_MSB 6'h18
`define CIE_OP_LOGIC_RIGHT_SHIFT 6'h19
`define CIE_OP_LOGIC_RIGHT_SHIFT_N 6'h1A
`define CIE_OP_ARITH_RIGHT_SHIFT_N 6'h1B
`define CIE_OP_LEFT_SHIFT_N 6'h1C
`define CIE_OP_MULTIPLY_TO_ACC 6'h1D
`define CIE_OP_MUL_ACCUMULATE 6'h1E
`define CIE_OP_MUL_SUBTRACT_ACC 6'h1F
`define CIE_OP_INT_MUL 6'h20
`define CIE_OP_LOW_WORD_PRODUCT 6'h21
`define CIE_OP_PAIR_MOVE 6'h22
`define CIE_OP_PAGE_LOAD 6'h23

// Branch condition codes on the cond port
`define CIE_CC_C 5'h00
`define CIE_CC_GE 5'h01
`define CIE_CC_GEU 5'h02
`define CIE_CC_GT 5'h03
`define CIE_CC_GTU 5'h04
`define CIE_CC_LE 5'h05
`define CIE_CC_LEU 5'h06
`define CIE_CC_LT 5'h07
`define CIE_CC_LTU 5'h08
`define CIE_CC_N 5'h09
`define CIE_CC_NC 5'h0A
`define CIE_CC_NN 5'h0B
`define CIE_CC_NOV 5'h0C
`define CIE_CC_NZ 5'h0D
`define CIE_CC_OA 5'h0E
`define CIE_CC_OB 5'h0F
`define CIE_CC_OV 5'h10
`define CIE_CC_SA 5'h11
`define CIE_CC_SB 5'h12
`define CIE_CC_Z 5'h13

// Compare relations on sel for compare-and-skip and compare-and-jump
`define CIE_REL_EQ 2'h0
`define CIE_REL_GT 2'h1
`define CIE_REL_LT 2'h2
`define CIE_REL_NE 2'h3

// Status bit positions
`define CIE_ST_C 0
`define CIE_ST_Z 1
`define CIE_ST_OV 2
`define CIE_ST_N 3
`define CIE_ST_DC 4
`define CIE_ST_SFA 5
`define CIE_ST_OA 6
`define CIE_ST_OB 7
`define CIE_ST_SA 8
`define CIE_ST_SB 9
`define CIE_ST_OAB 10
`define CIE_ST_SAB 11
`define CIE_ST_RESET 12'h000

// Cycle counts
`define CIE_CYC_ONE 5'h01
`define CIE_CYC_TWO 5'h02
`define CIE_CYC_SKIP_ONE_WORD 5'h02
`define CIE_CYC_SKIP_TWO_WORD 5'h03
`define CIE_CYC_BRANCH 5'h04
`define CIE_CYC_CALL 5'h04
`define CIE_CYC_CMP_JUMP 5'h05
`define CIE_CYC_DIV 5'h12
`define CIE_DIV_STEPS 5'h10

`endif

// ---- verilog/cie_div.v ----
/*
  Restoring unsigned divider, 32-bit dividend by 16-bit divisor, one
  quotient bit per clock; results settle 16 clocks after go.
  Assumes the caller has screened out overflow (dividend high word not
  below the divisor) and handles signs and timing itself.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cie_regs.vh"

module cie_div (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Operands
  input wire go,
  input wire [31:0] dividend,
  input wire [15:0] divisor,
  // Results
  output reg [15:0] quotient_r,
  output reg [15:0] remainder_r
);

  reg [15:0] dsr_r;
  reg [4:0] cnt_r;
  wire [16:0] trial;
  wire fits;

  assign trial = {remainder_r, quotient_r[15]};
  assign fits = trial >= {1'b0, dsr_r};

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      quotient_r <= 16'h0000;
      remainder_r <= 16'h0000;
      dsr_r <= 16'h0000;
      cnt_r <= 5'h00;
    end
    else if (go)
    begin
      remainder_r <= dividend[31:16];
      quotient_r <= dividend[15:0];
      dsr_r <= divisor;
      cnt_r <= `CIE_DIV_STEPS;
    end
    else if (cnt_r != 5'h00)
    begin
      cnt_r <= cnt_r - 5'h01;
      quotient_r <= {quotient_r[14:0], fits};
      if (fits)
        remainder_r <= trial[15:0] - dsr_r;
      else
        remainder_r <= trial[15:0];
    end
  end

endmodule // cie_div

`default_nettype wire

// ---- verilog/cie_core.v ----
/*
  Instruction execution block: takes one decoded instruction at a time
  with its operand values, produces result, status, accumulator and page
  updates, and holds busy for the instruction's cycle count.
  Assumes clk is the instruction cycle clock and that the fetch side
  supplies operand values and whether the following word is a second word.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cie_regs.vh"

module cie_core (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Instruction issue
  input wire start,
  input wire [5:0] op,
  input wire [4:0] cond,
  input wire [1:0] sel,
  input wire sgn_a,
  input wire sgn_b,
  input wire wide,
  input wire acc_sel,
  input wire [15:0] opa,
  input wire [15:0] opb,
  input wire [15:0] opc,
  input wire [3:0] bit_sel,
  input wire [14:0] lit,
  input wire periph,
  input wire next_two_word,
  input wire [7:0] word_hi,
  input wire orphan_word,
  // Completion
  output wire ready,
  output reg done_r,
  output reg [15:0] result_r,
  output reg [15:0] result_hi_r,
  output reg taken_r,
  output reg skip_r,
  output reg [1:0] words_r,
  output reg [4:0] cycles_r,
  // Core state
  output reg [11:0] status_r,
  output reg [39:0] acc_a_r,
  output reg [39:0] acc_b_r,
  output reg [9:0] data_read_page_r,
  output reg [8:0] data_write_page_r,
  output reg [7:0] table_page_reg_r,
  output reg [15:0] loop_count_r,
  output reg [15:0] loop_end_r,
  output wire irq_blocked
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DIV = 3'b100;

  // Returns {carry, digit carry, overflow, difference} of a - b - !cin
  function [18:0] cie_sub;
    input [15:0] a;
    input [15:0] b;
    input cin;
    reg [16:0] d;
    reg [4:0] dn;
    begin
      d = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
      dn = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      cie_sub = {d[16], dn[4], (a[15] ^ b[15]) & (a[15] ^ d[15]), d[15:0]};
    end
  endfunction

  reg [2:0] state_r;
  reg [4:0] rem_r;
  reg [13:0] irq_cnt_r;
  reg q_neg_r;
  reg r_neg_r;
  reg dv_ovf_r;
  reg dv_sgn_r;

  reg [4:0] cyc;
  reg [1:0] wd;
  reg tk;
  reg sk;
  reg [15:0] res;
  reg [15:0] hi;
  reg [11:0] st;
  reg [39:0] acc_a_n;
  reg [39:0] acc_b_n;
  reg bitv;
  reg hit;
  reg [4:0] pos;
  reg [8:0] bcd;
  reg [40:0] sum;
  reg [39:0] clip;
  reg [18:0] sd;
  integer i;

  wire [5:0] eff_op;
  wire [15:0] mask;
  wire [39:0] acc_cur;
  wire signed [16:0] mul_a;
  wire signed [16:0] mul_b;
  wire signed [33:0] prod;
  wire [39:0] prod40;
  wire rd_op;
  wire is_div;
  wire dv_sgn;
  wire [31:0] dvd;
  wire [31:0] dvd_mag;
  wire [15:0] dsr_mag;
  wire [15:0] quo;
  wire [15:0] rmd;
  wire q_ovf;
  wire [15:0] q_out;

  // A lone second word has a zero upper byte and must do nothing
  assign eff_op = (orphan_word && word_hi == 8'h00) ? `CIE_OP_NOP : op;
  assign ready = state_r == ST_IDLE;
  assign irq_blocked = irq_cnt_r != 14'h0000;
  assign mask = 16'h0001 << bit_sel;
  assign acc_cur = acc_sel ? acc_b_r : acc_a_r;
  assign mul_a = {sgn_a & opa[15], opa};
  assign mul_b = {sgn_b & opb[15], opb};
  assign prod = mul_a * mul_b;
  assign prod40 = {{6{prod[33]}}, prod};
  assign rd_op = (eff_op >= `CIE_OP_BIT_CLR && eff_op <= `CIE_OP_TEST_THEN_SET) ||
    eff_op == `CIE_OP_COMPARE || eff_op == `CIE_OP_COMPARE_BORROW;
  assign is_div = eff_op == `CIE_OP_INT_DIV || eff_op == `CIE_OP_FRAC_QUOTIENT;

  // Fractional divide is always signed and scales the dividend by 2^15
  assign dv_sgn = (eff_op == `CIE_OP_FRAC_QUOTIENT) | sgn_a;
  assign dvd = (eff_op == `CIE_OP_FRAC_QUOTIENT) ? {opa[15], opa, 15'h0000} :
    wide ? {opc, opa} : {{16{sgn_a & opa[15]}}, opa};
  assign dvd_mag = (dv_sgn & dvd[31]) ? 32'h00000000 - dvd : dvd;
  assign dsr_mag = (dv_sgn & opb[15]) ? 16'h0000 - opb : opb;
  assign q_ovf = dv_ovf_r | (dv_sgn_r & (q_neg_r ? quo > 16'h8000 : quo[15]));
  assign q_out = q_neg_r ? 16'h0000 - quo : quo;

  cie_div u_div (
    .clk(clk),
    .rstn(rstn),
    .go(ready & start & is_div),
    .dividend(dvd_mag),
    .divisor(dsr_mag),
    .quotient_r(quo),
    .remainder_r(rmd)
  );

  always @*
  begin
    cyc = `CIE_CYC_ONE;
    wd = 2'h1;
    tk = 1'b0;
    sk = 1'b0;
    res = result_r;
    hi = result_hi_r;
    st = status_r;
    acc_a_n = acc_a_r;
    acc_b_n = acc_b_r;
    bitv = opa[bit_sel];
    sd = 19'h00000;
    sum = 41'h00000000000;
    clip = 40'h0000000000;
    bcd = 9'h000;
    pos = 5'h00;
    for (i = 0; i < 16; i = i + 1)
      if (opa[i])
        pos = 5'h10 - i[4:0];
    case (sel)
      `CIE_REL_EQ: hit = opa == opb;
      `CIE_REL_GT: hit = $signed(opa) > $signed(opb);
      `CIE_REL_LT: hit = $signed(opa) < $signed(opb);
      default: hit = opa != opb;
    endcase
    case (eff_op)
      `CIE_OP_BIT_CLR: res = opa & ~mask;
      `CIE_OP_BIT_SET: res = opa | mask;
      `CIE_OP_BIT_TOG: res = opa ^ mask;
      `CIE_OP_BIT_TEST:
      begin
        if (sel[0])
          st[`CIE_ST_C] = bitv;
        else
          st[`CIE_ST_Z] = ~bitv;
      end
      `CIE_OP_TEST_SKIP_CLR, `CIE_OP_TEST_SKIP_SET:
      begin
        sk = bitv == (eff_op == `CIE_OP_TEST_SKIP_SET);
      end
      `CIE_OP_TEST_THEN_SET:
      begin
        if (sel[0])
          st[`CIE_ST_C] = bitv;
        else
          st[`CIE_ST_Z] = ~bitv;
        res = opa | mask;
      end
      `CIE_OP_JUMP_COND:
      begin
        case (cond)
          `CIE_CC_C: tk = status_r[`CIE_ST_C];
          `CIE_CC_GE: tk = status_r[`CIE_ST_N] == status_r[`CIE_ST_OV];
          `CIE_CC_GEU: tk = status_r[`CIE_ST_C];
          `CIE_CC_GT: tk = ~status_r[`CIE_ST_Z] & (status_r[`CIE_ST_N] == status_r[`CIE_ST_OV]);
          `CIE_CC_GTU: tk = status_r[`CIE_ST_C] & ~status_r[`CIE_ST_Z];
          `CIE_CC_LE: tk = status_r[`CIE_ST_Z] | (status_r[`CIE_ST_N] ^ status_r[`CIE_ST_OV]);
          `CIE_CC_LEU: tk = ~status_r[`CIE_ST_C] | status_r[`CIE_ST_Z];
          `CIE_CC_LT: tk = status_r[`CIE_ST_N] ^ status_r[`CIE_ST_OV];
          `CIE_CC_LTU: tk = ~status_r[`CIE_ST_C];
          `CIE_CC_N: tk = status_r[`CIE_ST_N];
          `CIE_CC_NC: tk = ~status_r[`CIE_ST_C];
          `CIE_CC_NN: tk = ~status_r[`CIE_ST_N];
          `CIE_CC_NOV: tk = ~status_r[`CIE_ST_OV];
          `CIE_CC_NZ: tk = ~status_r[`CIE_ST_Z];
          `CIE_CC_OA: tk = status_r[`CIE_ST_OA];
          `CIE_CC_OB: tk = status_r[`CIE_ST_OB];
          `CIE_CC_OV: tk = status_r[`CIE_ST_OV];
          `CIE_CC_SA: tk = status_r[`CIE_ST_SA];
          `CIE_CC_SB: tk = status_r[`CIE_ST_SB];
          `CIE_CC_Z: tk = status_r[`CIE_ST_Z];
          default: tk = 1'b0;
        endcase
        cyc = tk ? `CIE_CYC_BRANCH : `CIE_CYC_ONE;
      end
      `CIE_OP_JUMP_ALWAYS, `CIE_OP_JUMP_REG:
      begin
        tk = 1'b1;
        cyc = `CIE_CYC_BRANCH;
      end
      `CIE_OP_CALL_LIT, `CIE_OP_CALL_REG:
      begin
        tk = 1'b1;
        cyc = `CIE_CYC_CALL;
        wd = (eff_op == `CIE_OP_CALL_LIT) ? 2'h2 : 2'h1;
        st[`CIE_ST_SFA] = 1'b0;
      end
      `CIE_OP_GOTO_LIT, `CIE_OP_GOTO_REG:
      begin
        tk = 1'b1;
        cyc = `CIE_CYC_BRANCH;
        wd = (eff_op == `CIE_OP_GOTO_LIT) ? 2'h2 : 2'h1;
      end
      `CIE_OP_COMPARE, `CIE_OP_COMPARE_BORROW:
      begin
        if (eff_op == `CIE_OP_COMPARE)
          sd = cie_sub(opa, opb, 1'b1);
        else
          sd = cie_sub(opa, opb, status_r[`CIE_ST_C]);
        st[`CIE_ST_C] = sd[18];
        st[`CIE_ST_DC] = sd[17];
        st[`CIE_ST_OV] = sd[16];
        st[`CIE_ST_N] = sd[15];
        // Borrow form keeps zero sticky so multi-word compares chain
        if (eff_op == `CIE_OP_COMPARE)
          st[`CIE_ST_Z] = sd[15:0] == 16'h0000;
        else
          st[`CIE_ST_Z] = status_r[`CIE_ST_Z] & (sd[15:0] == 16'h0000);
      end
      `CIE_OP_CMP_SKIP: sk = hit;
      `CIE_OP_CMP_JUMP:
      begin
        tk = hit;
        cyc = hit ? `CIE_CYC_CMP_JUMP : `CIE_CYC_ONE;
      end
      `CIE_OP_INT_DIV, `CIE_OP_FRAC_QUOTIENT: cyc = `CIE_CYC_DIV;
      `CIE_OP_LOOP:
      begin
        cyc = `CIE_CYC_TWO;
        wd = 2'h2;
      end
      `CIE_OP_DECIMAL_ADJUST:
      begin
        bcd = {1'b0, opa[7:0]};
        if (bcd[3:0] > 4'h9 || status_r[`CIE_ST_DC])
          bcd = bcd + 9'h006;
        if (bcd[7:4] > 4'h9 || bcd[8] || status_r[`CIE_ST_C])
          bcd = bcd + 9'h060;
        res = {opa[15:8], bcd[7:0]};
        st[`CIE_ST_C] = bcd[8];
      end
      `CIE_OP_FIRST_ONE_FROM_MSB:
      begin
        res = {11'h000, pos};
        st[`CIE_ST_C] = opa == 16'h0000;
      end
      `CIE_OP_LOGIC_RIGHT_SHIFT:
      begin
        res = {1'b0, opa[15:1]};
        st[`CIE_ST_C] = opa[0];
        st[`CIE_ST_OV] = 1'b0;
      end
      `CIE_OP_LOGIC_RIGHT_SHIFT_N: res = opa >> opb[3:0];
      `CIE_OP_ARITH_RIGHT_SHIFT_N: res = $signed(opa) >>> opb[3:0];
      `CIE_OP_LEFT_SHIFT_N: res = opa << opb[3:0];
      `CIE_OP_MULTIPLY_TO_ACC, `CIE_OP_MUL_ACCUMULATE, `CIE_OP_MUL_SUBTRACT_ACC:
      begin
        if (eff_op == `CIE_OP_MULTIPLY_TO_ACC)
          sum = {prod40[39], prod40};
        else if (eff_op == `CIE_OP_MUL_ACCUMULATE)
          sum = {acc_cur[39], acc_cur} + {prod40[39], prod40};
        else
          sum = {acc_cur[39], acc_cur} - {prod40[39], prod40};
        // A true 40-bit overflow clips rather than wraps
        if (sum[40] != sum[39])
          clip = sum[40] ? 40'h8000000000 : 40'h7FFFFFFFFF;
        else
          clip = sum[39:0];
        if (acc_sel)
        begin
          acc_b_n = clip;
          st[`CIE_ST_OB] = ~(&clip[39:31] | ~|clip[39:31]);
          st[`CIE_ST_SB] = status_r[`CIE_ST_SB] | (sum[40] != sum[39]);
        end
        else
        begin
          acc_a_n = clip;
          st[`CIE_ST_OA] = ~(&clip[39:31] | ~|clip[39:31]);
          st[`CIE_ST_SA] = status_r[`CIE_ST_SA] | (sum[40] != sum[39]);
        end
        st[`CIE_ST_OAB] = st[`CIE_ST_OA] | st[`CIE_ST_OB];
        st[`CIE_ST_SAB] = st[`CIE_ST_SA] | st[`CIE_ST_SB];
      end
      `CIE_OP_INT_MUL:
      begin
        if (sel[0])
        begin
          if (acc_sel)
            acc_b_n = {{8{prod40[31]}}, prod40[31:0]};
          else
            acc_a_n = {{8{prod40[31]}}, prod40[31:0]};
        end
        else
        begin
          res = prod[15:0];
          hi = prod[31:16];
        end
      end
      `CIE_OP_LOW_WORD_PRODUCT: res = prod[15:0];
      `CIE_OP_PAIR_MOVE:
      begin
        res = opa;
        hi = opc;
        cyc = `CIE_CYC_TWO;
      end
      default: cyc = `CIE_CYC_ONE;
    endcase
    if (eff_op >= `CIE_OP_LOGIC_RIGHT_SHIFT && eff_op <= `CIE_OP_LEFT_SHIFT_N)
    begin
      st[`CIE_ST_N] = res[15];
      st[`CIE_ST_Z] = res == 16'h0000;
    end
    if (sk)
      cyc = next_two_word ? `CIE_CYC_SKIP_TWO_WORD : `CIE_CYC_SKIP_ONE_WORD;
    if (periph && rd_op)
      cyc = cyc + 5'h01;
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      rem_r <= 5'h00;
      irq_cnt_r <= 14'h0000;
      q_neg_r <= 1'b0;
      r_neg_r <= 1'b0;
      dv_ovf_r <= 1'b0;
      dv_sgn_r <= 1'b0;
      done_r <= 1'b0;
      result_r <= 16'h0000;
      result_hi_r <= 16'h0000;
      taken_r <= 1'b0;
      skip_r <= 1'b0;
      words_r <= 2'h1;
      cycles_r <= 5'h00;
      status_r <= `CIE_ST_RESET;
      acc_a_r <= 40'h0000000000;
      acc_b_r <= 40'h0000000000;
      data_read_page_r <= 10'h000;
      data_write_page_r <= 9'h000;
      table_page_reg_r <= 8'h00;
      loop_count_r <= 16'h0000;
      loop_end_r <= 16'h0000;
    end
    else
    begin
      done_r <= 1'b0;
      if (irq_cnt_r != 14'h0000)
        irq_cnt_r <= irq_cnt_r - 14'h0001;
      case (state_r)
        ST_IDLE:
        begin
          if (start)
          begin
            result_r <= res;
            result_hi_r <= hi;
            status_r <= st;
            acc_a_r <= acc_a_n;
            acc_b_r <= acc_b_n;
            taken_r <= tk;
            skip_r <= sk;
            words_r <= wd;
            cycles_r <= cyc;
            rem_r <= cyc - 5'h01;
            if (eff_op == `CIE_OP_IRQ_HOLD)
              irq_cnt_r <= lit[13:0];
            if (eff_op == `CIE_OP_LOOP)
            begin
              loop_count_r <= sel[0] ? opb : {1'b0, lit};
              loop_end_r <= opa;
            end
            if (eff_op == `CIE_OP_PAGE_LOAD)
            begin
              // Literal or register source; only the low bits are kept
              case (sel)
                2'h0: data_read_page_r <= opa[9:0];
                2'h1: data_write_page_r <= opa[8:0];
                default: table_page_reg_r <= opa[7:0];
              endcase
            end
            q_neg_r <= dv_sgn & (dvd[31] ^ opb[15]);
            r_neg_r <= dv_sgn & dvd[31];
            dv_sgn_r <= dv_sgn;
            dv_ovf_r <= dsr_mag == 16'h0000 || dvd_mag[31:16] >= dsr_mag;
            if (cyc == `CIE_CYC_ONE)
              done_r <= 1'b1;
            else
              state_r <= is_div ? ST_DIV : ST_WAIT;
          end
        end
        ST_WAIT, ST_DIV:
        begin
          rem_r <= rem_r - 5'h01;
          if (rem_r == 5'h01)
          begin
            done_r <= 1'b1;
            state_r <= ST_IDLE;
            if (state_r == ST_DIV)
            begin
              result_r <= q_out;
              result_hi_r <= r_neg_r ? 16'h0000 - rmd : rmd;
              status_r[`CIE_ST_N] <= q_out[15];
              status_r[`CIE_ST_Z] <= q_out == 16'h0000;
              status_r[`CIE_ST_C] <= rmd != 16'h0000;
              status_r[`CIE_ST_OV] <= q_ovf;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // cie_core

`default_nettype wire

// ---- testbench/cie_core_asserts.sv ----
/* Timing and flag checks for cie_core. Sees only the core's ports. */
`timescale 1ns/10ps
`default_nettype none
`include "cie_regs.vh"
module cie_core_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Issue
  input wire logic start,
  input wire logic [5:0] op,
  input wire logic periph,
  input wire logic next_two_word,
  // Completion
  input wire logic ready,
  input wire logic done_r,
  input wire logic taken_r,
  input wire logic skip_r,
  input wire logic [1:0] words_r,
  input wire logic [4:0] cycles_r,
  input wire logic [11:0] status_r
);
  wire take = start && ready;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  brn_taken_a: assert property (take && op == `CIE_OP_JUMP_COND ##1 taken_r
    |-> !ready [*3] ##1 (ready && done_r)) else $error("taken branch timing");
  brn_untaken_a: assert property (take && op == `CIE_OP_JUMP_COND ##1 !taken_r
    |-> done_r && cycles_r == 5'h01) else $error("untaken branch timing");
  brn_flags_a: assert property (take && op == `CIE_OP_JUMP_COND
    |=> $stable(status_r)) else $error("branch changed status");
  skip_cost_a: assert property (take && op == `CIE_OP_TEST_SKIP_CLR && !periph
    |=> cycles_r == (skip_r ? 5'h02 + $past(next_two_word) : 5'h01))
    else $error("skip cycle count");
  call_shape_a: assert property (take && op == `CIE_OP_CALL_LIT
    |=> words_r == 2'h2 && cycles_r == 5'h04) else $error("call shape");
  div_done_a: assert property (take && op == `CIE_OP_INT_DIV
    |-> ##18 done_r && cycles_r == 5'h12) else $error("divide timing");
  mul_flags_a: assert property (take && op == `CIE_OP_INT_MUL
    |=> $stable(status_r) && done_r) else $error("multiply flags or timing");
  periph_cost_a: assert property (take && op == `CIE_OP_TEST_THEN_SET && periph
    |=> cycles_r == 5'h02) else $error("peripheral extra cycle");
endmodule // cie_core_asserts
bind cie_core cie_core_asserts u_chk (.clk(clk), .rstn(rstn), .start(start), .op(op),
  .periph(periph), .next_two_word(next_two_word), .ready(ready), .done_r(done_r),
  .taken_r(taken_r), .skip_r(skip_r), .words_r(words_r), .cycles_r(cycles_r),
  .status_r(status_r));
`default_nettype wire

// ---- testbench/cie_fetch_model.sv ----
/* Fetch-side model: upper bytes of a four-word program. Bench gives pc. */
`timescale 1ns/10ps
`default_nettype none
module cie_fetch_model (
  // Program position
  input wire logic [1:0] pc,
  // To the core
  output logic next_two_word,
  output logic [7:0] word_hi,
  output logic orphan_word
);
  // Words 1 and 3 are second words, so their upper byte is zero
  wire [31:0] mem = 32'h00020004;
  wire [1:0] nxt = pc + 2'h2;
  assign word_hi = mem[pc * 8 +: 8];
  assign next_two_word = mem[nxt * 8 +: 8] == 8'h00;
  assign orphan_word = pc == 2'h3;
endmodule // cie_fetch_model
`default_nettype wire

// ---- testbench/tb_cie_core.sv ----
/* Self-checking bench for cie_core. Assumes the fetch model and checker. */
`timescale 1ns/10ps
`default_nettype none
`include "cie_regs.vh"
`define CHK(a, b) begin n_checks = n_checks + 1; if ((a) !== (b)) begin \
  err_count = err_count + 1; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_cie_core;
  logic clk, rstn, start, sgn_a, sgn_b, wide, acc_sel, periph, next_two_word, orphan_word;
  logic [5:0] op;
  logic [4:0] cond;
  logic [1:0] sel, pc;
  logic [15:0] opa, opb, opc;
  logic [3:0] bit_sel;
  logic [14:0] lit;
  logic [7:0] word_hi;
  wire ready, done_r, taken_r, skip_r;
  wire [15:0] result_r, result_hi_r;
  wire [1:0] words_r;
  wire [4:0] cycles_r;
  wire [11:0] status_r;
  wire [9:0] rpg;
  wire [8:0] wpg;
  wire [7:0] tpg;
  wire [39:0] acc_a, acc_b;
  wire [15:0] lpc, lpe;
  wire irqb;
  integer err_count, n_checks, cyc;
  cie_fetch_model fetch (.pc(pc), .next_two_word(next_two_word), .word_hi(word_hi),
    .orphan_word(orphan_word));
  cie_core dut (.clk(clk), .rstn(rstn), .start(start), .op(op), .cond(cond), .sel(sel),
    .sgn_a(sgn_a), .sgn_b(sgn_b), .wide(wide), .acc_sel(acc_sel), .opa(opa), .opb(opb),
    .opc(opc), .bit_sel(bit_sel), .lit(lit), .periph(periph), .next_two_word(next_two_word),
    .word_hi(word_hi), .orphan_word(orphan_word), .ready(ready), .done_r(done_r),
    .result_r(result_r), .result_hi_r(result_hi_r), .taken_r(taken_r), .skip_r(skip_r),
    .words_r(words_r), .cycles_r(cycles_r), .status_r(status_r), .acc_a_r(acc_a),
    .acc_b_r(acc_b), .data_read_page_r(rpg), .data_write_page_r(wpg), .table_page_reg_r(tpg),
    .loop_count_r(lpc), .loop_end_r(lpe), .irq_blocked(irqb));
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task report_and_stop;
  begin
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // Issue on a falling edge, drop start after the taking edge, wait for done
  task run(input [5:0] o, input [15:0] a, input [15:0] b, input [1:0] s, input [3:0] bs);
    integer k;
  begin
    op = o; opa = a; opb = b; sel = s; bit_sel = bs; start = 1;
    @(negedge clk);
    start = 0;
    k = 0;
    while (done_r !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k = k + 1;
    end
  end
  endtask
  task t_bits;
  begin
    run(`CIE_OP_TEST_THEN_SET, 16'h0008, 0, 2'h1, 4'h3);
    `CHK(status_r[0], 1'b1)
    `CHK(result_r, 16'h0008)
    periph = 1;
    run(`CIE_OP_TEST_THEN_SET, 0, 0, 2'h0, 4'h0);
    `CHK(status_r[1:0], 2'h3)
    `CHK(cycles_r, 5'h02)
    periph = 0;
    pc = 2'h1;
    run(`CIE_OP_TEST_SKIP_CLR, 0, 0, 2'h0, 4'h2);
    `CHK(skip_r, 1'b1)
    `CHK(cycles_r, 5'h03)
    pc = 2'h3;
    run(`CIE_OP_TEST_THEN_SET, 0, 0, 2'h1, 4'h0);
    `CHK(status_r[0], 1'b1)
    pc = 2'h0;
  end
  endtask
  task t_branch;
  begin
    cond = `CIE_CC_Z;
    run(`CIE_OP_JUMP_COND, 0, 0, 2'h0, 4'h0);
    `CHK(cycles_r, 5'h04)
    cond = `CIE_CC_NZ;
    run(`CIE_OP_JUMP_COND, 0, 0, 2'h0, 4'h0);
    `CHK(taken_r, 1'b0)
    `CHK(status_r, 12'h003)
  end
  endtask
  task t_arith;
    logic [11:0] s;
  begin
    run(`CIE_OP_INT_DIV, 16'h0064, 16'h0007, 2'h0, 4'h0);
    `CHK(result_r, 16'h000E)
    `CHK(result_hi_r, 16'h0002)
    `CHK(cycles_r, 5'h12)
    s = status_r;
    sgn_a = 1;
    sgn_b = 1;
    run(`CIE_OP_INT_MUL, 16'hFFFF, 16'h0002, 2'h0, 4'h0);
    `CHK({result_hi_r, result_r}, 32'hFFFFFFFE)
    `CHK(status_r, s)
  end
  endtask
  task t_ctrl;
  begin
    run(`CIE_OP_CALL_LIT, 0, 0, 2'h0, 4'h0);
    `CHK(words_r, 2'h2)
    // Distinct values per page catch a load that writes every page
    run(`CIE_OP_PAGE_LOAD, 16'hFE5A, 0, 2'h0, 4'h0);
    run(`CIE_OP_PAGE_LOAD, 16'h0133, 0, 2'h1, 4'h0);
    run(`CIE_OP_PAGE_LOAD, 16'h00C4, 0, 2'h2, 4'h0);
    `CHK({rpg, wpg, tpg}, 27'h4B533C4)
  end
  endtask
  task t_cmp;
  begin
    run(`CIE_OP_COMPARE_BORROW, 16'h0005, 16'h0005, 2'h0, 4'h0);
    `CHK(status_r, 12'h011)
    run(`CIE_OP_COMPARE_BORROW, 16'h0003, 16'h0005, 2'h0, 4'h0);
    `CHK(status_r, 12'h008)
    run(`CIE_OP_COMPARE_BORROW, 16'h0005, 16'h0005, 2'h0, 4'h0);
    `CHK(status_r, 12'h008)
    run(`CIE_OP_COMPARE_BORROW, 16'h8000, 16'h0001, 2'h0, 4'h0);
    `CHK(status_r, 12'h005)
    run(`CIE_OP_CMP_SKIP, 16'hFFFF, 16'h0001, `CIE_REL_LT, 4'h0);
    `CHK({skip_r, cycles_r}, 6'h22)
    run(`CIE_OP_CMP_SKIP, 16'hFFFF, 16'h0001, `CIE_REL_GT, 4'h0);
    `CHK({skip_r, cycles_r, status_r}, 18'h01005)
    run(`CIE_OP_CMP_JUMP, 16'h0002, 16'h0002, `CIE_REL_EQ, 4'h0);
    `CHK({taken_r, cycles_r}, 6'h25)
    run(`CIE_OP_CMP_JUMP, 16'h0002, 16'h0002, `CIE_REL_NE, 4'h0);
    `CHK({taken_r, cycles_r}, 6'h01)
    run(`CIE_OP_GOTO_LIT, 0, 0, 2'h0, 4'h0);
    `CHK({words_r, cycles_r}, 7'h44)
    run(`CIE_OP_GOTO_REG, 0, 0, 2'h0, 4'h0);
    `CHK({words_r, cycles_r, status_r}, 19'h24005)
  end
  endtask
  task t_misc;
  begin
    lit = 15'h0005;
    run(`CIE_OP_IRQ_HOLD, 0, 0, 2'h0, 4'h0);
    `CHK(irqb, 1'b1)
    repeat (4) @(negedge clk);
    `CHK(irqb, 1'b1)
    @(negedge clk);
    `CHK(irqb, 1'b0)
    run(`CIE_OP_LOOP, 16'h0123, 16'h0042, 2'h0, 4'h0);
    `CHK({lpc, lpe}, 32'h00050123)
    `CHK({words_r, cycles_r}, 7'h42)
    run(`CIE_OP_LOOP, 16'h0123, 16'h0042, 2'h1, 4'h0);
    `CHK(lpc, 16'h0042)
    run(`CIE_OP_FIRST_ONE_FROM_MSB, 0, 0, 2'h0, 4'h0);
    `CHK({result_r, status_r}, 28'h0000005)
    run(`CIE_OP_FIRST_ONE_FROM_MSB, 16'h0100, 0, 2'h0, 4'h0);
    `CHK({result_r, status_r}, 28'h0008004)
    run(`CIE_OP_DECIMAL_ADJUST, 16'h129A, 0, 2'h0, 4'h0);
    `CHK({result_r, status_r}, 28'h1200005)
    run(`CIE_OP_LOGIC_RIGHT_SHIFT, 16'h0003, 0, 2'h0, 4'h0);
    `CHK({result_r, status_r}, 28'h0001001)
    run(`CIE_OP_LEFT_SHIFT_N, 16'h0001, 16'h000F, 2'h0, 4'h0);
    `CHK({result_r, status_r}, 28'h8000009)
    opc = 16'h2222;
    run(`CIE_OP_PAIR_MOVE, 16'h1111, 0, 2'h0, 4'h0);
    `CHK({result_hi_r, result_r}, 32'h22221111)
    `CHK({words_r, cycles_r}, 7'h22)
    run(`CIE_OP_LOW_WORD_PRODUCT, 16'h0100, 16'h0100, 2'h0, 4'h0);
    `CHK({result_hi_r, result_r}, 32'h22220000)
    run(`CIE_OP_FRAC_QUOTIENT, 16'hE000, 16'h4000, 2'h0, 4'h0);
    `CHK({cycles_r, result_r, status_r}, 33'h12C000008)
  end
  endtask
  task t_acc;
  begin
    acc_sel = 0;
    run(`CIE_OP_MULTIPLY_TO_ACC, 16'h0003, 16'h0004, 2'h0, 4'h0);
    acc_sel = 1;
    run(`CIE_OP_MULTIPLY_TO_ACC, 16'h8000, 16'h8000, 2'h0, 4'h0);
    run(`CIE_OP_MUL_ACCUMULATE, 16'h8000, 16'h8000, 2'h0, 4'h0);
    `CHK({acc_a, acc_b}, 80'h000000000C0080000000)
    `CHK(status_r, 12'h488)
    cond = `CIE_CC_OB;
    run(`CIE_OP_JUMP_COND, 0, 0, 2'h0, 4'h0);
    `CHK(taken_r, 1'b1)
    acc_sel = 0;
    run(`CIE_OP_MUL_SUBTRACT_ACC, 16'h0003, 16'h0004, 2'h0, 4'h0);
    `CHK(acc_a, 40'h0000000000)
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end
  initial
  begin
    rstn = 0; start = 0; op = 0; cond = 0; sel = 0; sgn_a = 0; sgn_b = 0; wide = 0;
    acc_sel = 0; opa = 0; opb = 0; opc = 0; bit_sel = 0; lit = 0; periph = 0; pc = 0;
    err_count = 0; n_checks = 0; cyc = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rstn = 1;
    t_bits;
    t_branch;
    t_arith;
    t_ctrl;
    t_cmp;
    t_misc;
    t_acc;
    report_and_stop;
  end
endmodule // tb_cie_core
`default_nettype wire
